// >>> logic/rcu_defines.svh
/*
  Constants of the reset control unit: register offsets, field positions,
  reset values and timing counts.
  Assumes it is included by its bare name; the guard lets the package and
  the top module both include it.
*/
`ifndef RCU_DEFINES_SVH
`define RCU_DEFINES_SVH

`define RCU_ADDR_W          4
`define RCU_DATA_W          8
`define RCU_SRC_W           3

`define RCU_OFS_FLAGS       4'h0
`define RCU_OFS_LVD_CTRL    4'h1
`define RCU_OFS_IRQ_STATUS  4'h2
`define RCU_OFS_IRQ_CLEAR   4'h3
`define RCU_OFS_IRQ_ENABLE  4'h4
`define RCU_OFS_STATE       4'h5

`define RCU_SRC_LVD         0
`define RCU_SRC_WDT         1
`define RCU_SRC_EXT         2

`define RCU_LVD_CTRL_EN     0
`define RCU_STATE_IN_RESET  0
`define RCU_STATE_STOP_EXIT 1

`define RCU_SRC_ZERO        3'h0
`define RCU_DATA_ZERO       8'h00

`define RCU_CLK_PERIOD_NS   20
`define RCU_MIN_PULSE_US    10
`define RCU_MIN_PULSE_CYC   ((`RCU_MIN_PULSE_US * 1000 + `RCU_CLK_PERIOD_NS - 1) / `RCU_CLK_PERIOD_NS)
`define RCU_PULSE_CNT_W     10
`define RCU_RELEASE_CYC     4
`define RCU_REL_CNT_W       3

`endif

// >>> logic/rcu_pkg.sv
/*
  Types of the reset control unit: states, carriers and the state record.
  Assumes rcu_defines.svh is on the include path.
*/
package rcu_pkg;
  `include "rcu_defines.svh"

  typedef enum logic [2:0] {
    RCU_ST_RUN  = 3'b001,
    RCU_ST_HOLD = 3'b010,
    RCU_ST_REL  = 3'b100
  } rcu_state_e;

  typedef struct packed {
    logic main_crystal_clock_en;
    logic subsystem_crystal_clock_en;
    logic int_high_speed_osc_en;
    logic int_low_speed_osc_en;
    logic ext_main_clock_valid;
  } rcu_clk_ctl_s;

  typedef struct packed {
    logic power_on_clear;
    logic low_voltage_detector;
    logic watchdog_overflow;
  } rcu_req_s;

  typedef struct packed {
    logic [`RCU_ADDR_W-1:0] addr;
    logic [`RCU_DATA_W-1:0] wdata;
    logic                   wr;
    logic                   rd;
  } rcu_bus_s;

  typedef struct packed {
    rcu_state_e                  st;
    logic [`RCU_PULSE_CNT_W-1:0] pulse_cnt;
    logic [`RCU_REL_CNT_W-1:0]   rel_cnt;
    logic                        stop_exit;
    logic                        non_lvd_cause;
    logic [`RCU_SRC_W-1:0]       flags;
    logic                        lvd_sw_en;
    logic [`RCU_SRC_W-1:0]       irq_status;
    logic [`RCU_SRC_W-1:0]       irq_enable;
    logic [`RCU_DATA_W-1:0]      rdata;
    logic                        irq;
    rcu_clk_ctl_s                clk_ctl;
    logic                        system_reset;
    logic                        sfr_init;
    logic                        port_force_hiz;
    logic                        ded_pin_out;
    logic                        ded_pin_oe;
    logic                        ram_write_block;
    logic                        ram_retain_stop;
    logic                        lvd_reset;
    logic                        wdt_reset;
  } rcu_regs_s;

endpackage : rcu_pkg

// >>> logic/rcu_top.sv
/*
  Reset control unit: merges the external reset pin, power-on clear,
  low-voltage detector and watchdog into one internal reset, gates the
  oscillators, forces pins safe and keeps the reset-source flags.
  Assumes every input is synchronous to core_clk, rst is the block's own
  power reset, and the port, RAM and oscillator blocks obey its outputs.
*/
// Added by the designer: the register offsets and the strobed register port.
// Notes on behaviour
// - All four oscillators are stopped while the internal reset is held.
// - The external main clock is flagged invalid during reset.
// - RAM is write-blocked and kept whenever reset ends STOP mode.
// - Registers initialise, ports float, the dedicated pin drives low.
// - A low-voltage reset never resets the low-voltage detector itself.
// - A watchdog overflow reset also resets the watchdog timer.
// - The low-voltage flag may be set right after power-up.
// - Default-enabled detector holds reset until supply is above threshold.
// - A power-on clear wipes the whole flag register to zero.
`timescale 1ns/100ps
`include "rcu_defines.svh"

module rcu_top (
  input  wire logic              core_clk,
  input  wire logic              rst,
  input  wire logic              reset_pin_n,
  input  rcu_pkg::rcu_req_s      req,
  input  wire logic              low_voltage_default_disable,
  input  wire logic              supply_above_threshold,
  input  wire logic              stop_mode,
  input  wire logic              ded_pin_sw_out,
  input  wire logic              ded_pin_sw_oe,
  input  rcu_pkg::rcu_bus_s      bus,
  output logic [7:0]             rdata,
  output logic                   irq,
  output rcu_pkg::rcu_clk_ctl_s  clk_ctl,
  output logic                   system_reset,
  output logic                   sfr_init,
  output logic                   port_force_hiz,
  output logic                   dedicated_low_output_port_pin_out,
  output logic                   dedicated_low_output_port_pin_oe,
  output logic                   ram_write_block,
  output logic                   ram_retain_stop,
  output logic                   low_voltage_detector_reset,
  output logic                   watchdog_reset
);
  import rcu_pkg::*;

  localparam logic [`RCU_PULSE_CNT_W-1:0] PULSE_LAST =
    `RCU_PULSE_CNT_W'(`RCU_MIN_PULSE_CYC - 1);
  localparam logic [`RCU_REL_CNT_W-1:0]   REL_LAST   =
    `RCU_REL_CNT_W'(`RCU_RELEASE_CYC - 1);

  rcu_regs_s s;
  rcu_regs_s next_s;

  always_comb begin
    logic                   ext_low;
    logic                   ext_hit;
    logic                   lvd_en;
    logic                   lvd_hold;
    logic                   lvd_cause;
    logic                   other_cause;
    logic                   any_req;
    logic                   in_reset;
    logic                   rd_flags;
    logic                   wr_ctrl;
    logic                   wr_clr;
    logic                   wr_en;
    logic [`RCU_SRC_W-1:0]  cause;
    logic [`RCU_SRC_W-1:0]  event_bits;

    next_s      = s;
    ext_low     = ~reset_pin_n;
    ext_hit     = 1'b0;
    lvd_en      = 1'b0;
    lvd_hold    = 1'b0;
    lvd_cause   = 1'b0;
    other_cause = 1'b0;
    any_req     = 1'b0;
    in_reset    = 1'b0;
    rd_flags    = 1'b0;
    wr_ctrl     = 1'b0;
    wr_clr      = 1'b0;
    wr_en       = 1'b0;
    cause       = `RCU_SRC_ZERO;
    event_bits  = `RCU_SRC_ZERO;

    // Short glitches on the pin never reset the chip
    if (ext_low) begin
      if (s.pulse_cnt != PULSE_LAST) begin
        next_s.pulse_cnt = s.pulse_cnt + `RCU_PULSE_CNT_W'(1);
      end
    end else begin
      next_s.pulse_cnt = '0;
    end
    ext_hit = ext_low && (s.pulse_cnt == PULSE_LAST);

    // Detector enabled by option byte or by software
    lvd_en    = ~low_voltage_default_disable | s.lvd_sw_en;
    lvd_hold  = ~low_voltage_default_disable & ~supply_above_threshold;
    lvd_cause = (lvd_en & req.low_voltage_detector) | lvd_hold;

    other_cause = req.power_on_clear | ext_hit | req.watchdog_overflow;
    any_req     = other_cause | lvd_cause;

    cause[`RCU_SRC_LVD] = lvd_cause;
    cause[`RCU_SRC_WDT] = req.watchdog_overflow;
    cause[`RCU_SRC_EXT] = ext_hit;

    case (s.st)
      RCU_ST_RUN: begin
        if (any_req) begin
          next_s.st            = RCU_ST_HOLD;
          next_s.stop_exit     = stop_mode;
          next_s.non_lvd_cause = other_cause;
          event_bits           = cause;
        end
      end
      RCU_ST_HOLD: begin
        next_s.non_lvd_cause = s.non_lvd_cause | other_cause;
        if (!any_req) begin
          next_s.st      = RCU_ST_REL;
          next_s.rel_cnt = '0;
        end
      end
      RCU_ST_REL: begin
        if (any_req) begin
          next_s.st            = RCU_ST_HOLD;
          next_s.non_lvd_cause = s.non_lvd_cause | other_cause;
        end else if (s.rel_cnt == REL_LAST) begin
          next_s.st            = RCU_ST_RUN;
          next_s.stop_exit     = 1'b0;
          next_s.non_lvd_cause = 1'b0;
        end else begin
          next_s.rel_cnt = s.rel_cnt + `RCU_REL_CNT_W'(1);
        end
      end
      default: begin
        next_s.st = RCU_ST_HOLD;
      end
    endcase

    in_reset = (next_s.st != RCU_ST_RUN);

    // Bus decode
    rd_flags = bus.rd && (bus.addr == `RCU_OFS_FLAGS);
    wr_ctrl  = bus.wr && (bus.addr == `RCU_OFS_LVD_CTRL);
    wr_clr   = bus.wr && (bus.addr == `RCU_OFS_IRQ_CLEAR);
    wr_en    = bus.wr && (bus.addr == `RCU_OFS_IRQ_ENABLE);

    // Flags clear on a whole-byte read; a cause in the same cycle still lands
    if (req.power_on_clear) begin
      next_s.flags = `RCU_SRC_ZERO;
    end else begin
      if (rd_flags) begin
        next_s.flags = `RCU_SRC_ZERO;
      end
      next_s.flags = next_s.flags | cause;
    end

    // Detector setting survives its own reset, not the others
    if (other_cause) begin
      next_s.lvd_sw_en = 1'b0;
    end else if (wr_ctrl && !in_reset) begin
      next_s.lvd_sw_en = bus.wdata[`RCU_LVD_CTRL_EN];
    end

    if (wr_en) begin
      next_s.irq_enable = bus.wdata[`RCU_SRC_W-1:0];
    end
    next_s.irq_status = s.irq_status;
    if (wr_clr) begin
      next_s.irq_status = s.irq_status & ~bus.wdata[`RCU_SRC_W-1:0];
    end
    next_s.irq_status = next_s.irq_status | event_bits;
    next_s.irq        = |(next_s.irq_status & next_s.irq_enable);

    // Read data stand one cycle after the strobe only
    next_s.rdata = `RCU_DATA_ZERO;
    if (bus.rd) begin
      case (bus.addr)
        `RCU_OFS_FLAGS: begin
          next_s.rdata[`RCU_SRC_W-1:0] = s.flags;
        end
        `RCU_OFS_LVD_CTRL: begin
          next_s.rdata[`RCU_LVD_CTRL_EN] = s.lvd_sw_en;
        end
        `RCU_OFS_IRQ_STATUS: begin
          next_s.rdata[`RCU_SRC_W-1:0] = s.irq_status;
        end
        `RCU_OFS_IRQ_ENABLE: begin
          next_s.rdata[`RCU_SRC_W-1:0] = s.irq_enable;
        end
        `RCU_OFS_STATE: begin
          next_s.rdata[`RCU_STATE_IN_RESET]  = (s.st != RCU_ST_RUN);
          next_s.rdata[`RCU_STATE_STOP_EXIT] = s.stop_exit;
        end
        default: begin
          next_s.rdata = `RCU_DATA_ZERO;
        end
      endcase
    end

    // Oscillators off and external clock ignored while held
    next_s.clk_ctl.main_crystal_clock_en      = ~in_reset;
    next_s.clk_ctl.subsystem_crystal_clock_en = ~in_reset;
    next_s.clk_ctl.int_high_speed_osc_en      = ~in_reset;
    next_s.clk_ctl.int_low_speed_osc_en       = ~in_reset;
    next_s.clk_ctl.ext_main_clock_valid       = ~in_reset;

    next_s.system_reset   = in_reset;
    next_s.sfr_init       = in_reset;
    next_s.port_force_hiz = in_reset;
    next_s.ded_pin_out    = in_reset ? 1'b0 : ded_pin_sw_out;
    next_s.ded_pin_oe     = in_reset ? 1'b1 : ded_pin_sw_oe;

    // RAM keeps its contents: writes are blocked for every reset
    next_s.ram_write_block = in_reset;
    next_s.ram_retain_stop = in_reset & next_s.stop_exit;

    next_s.lvd_reset = in_reset & next_s.non_lvd_cause;
    next_s.wdt_reset = in_reset;
  end

  // Power reset leaves the chip held, as if just powered
  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      s            <= '0;
      s.st         <= RCU_ST_HOLD;
      s.system_reset   <= 1'b1;
      s.sfr_init       <= 1'b1;
      s.port_force_hiz <= 1'b1;
      s.ded_pin_oe     <= 1'b1;
      s.ram_write_block <= 1'b1;
      s.lvd_reset      <= 1'b1;
      s.wdt_reset      <= 1'b1;
      s.non_lvd_cause  <= 1'b1;
    end else begin
      s <= next_s;
    end
  end

  assign rdata                             = s.rdata;
  assign irq                               = s.irq;
  assign clk_ctl                           = s.clk_ctl;
  assign system_reset                      = s.system_reset;
  assign sfr_init                          = s.sfr_init;
  assign port_force_hiz                    = s.port_force_hiz;
  assign dedicated_low_output_port_pin_out = s.ded_pin_out;
  assign dedicated_low_output_port_pin_oe  = s.ded_pin_oe;
  assign ram_write_block                   = s.ram_write_block;
  assign ram_retain_stop                   = s.ram_retain_stop;
  assign low_voltage_detector_reset        = s.lvd_reset;
  assign watchdog_reset                    = s.wdt_reset;

endmodule : rcu_top

// >>> dv/rcu_assertions.sv
/*
  Checker of the reset control unit, bound to rcu_top.
  Assumes one core_clk domain and the rcu_pkg types.
*/
`timescale 1ns/100ps
module rcu_assertions (
  input wire logic             core_clk,
  input wire logic             rst,
  input wire logic             reset_pin_n,
  input rcu_pkg::rcu_req_s     req,
  input wire logic             low_voltage_default_disable,
  input wire logic             supply_above_threshold,
  input wire logic             stop_mode,
  input rcu_pkg::rcu_bus_s     bus,
  input wire logic [7:0]       rdata,
  input rcu_pkg::rcu_clk_ctl_s clk_ctl,
  input wire logic             system_reset,
  input wire logic             sfr_init,
  input wire logic             port_force_hiz,
  input wire logic             dedicated_low_output_port_pin_out,
  input wire logic             dedicated_low_output_port_pin_oe,
  input wire logic             ram_write_block,
  input wire logic             ram_retain_stop,
  input wire logic             low_voltage_detector_reset,
  input wire logic             watchdog_reset
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  a_osc_stop: assert property (
    system_reset |-> clk_ctl[4:1] == 4'h0) else $error("Oscillator running in reset");
  a_ext_clk_invalid: assert property (
    system_reset |-> !clk_ctl.ext_main_clock_valid) else $error("External clock valid in reset");
  a_ram_kept: assert property (
    $rose(system_reset) && $past(stop_mode) |-> ram_retain_stop && ram_write_block)
    else $error("RAM not kept on stop exit");
  a_port_safe: assert property (
    system_reset |-> sfr_init && port_force_hiz && dedicated_low_output_port_pin_oe
    && !dedicated_low_output_port_pin_out) else $error("Pins not safe in reset");
  a_lvd_untouched: assert property (
    $rose(system_reset) && !$past(req.power_on_clear) && !$past(req.watchdog_overflow) && $past(reset_pin_n)
    |-> !low_voltage_detector_reset) else $error("Detector reset by its own trip");
  a_wdt_self: assert property (
    $past(req.watchdog_overflow) && !$past(system_reset) |-> system_reset && watchdog_reset)
    else $error("Watchdog reset missing");
  a_supply_hold: assert property (
    !low_voltage_default_disable && !supply_above_threshold |=> system_reset) else $error("Released at low supply");
  a_poc_wipe: assert property (
    req.power_on_clear && $past(req.power_on_clear) && bus.rd && bus.addr == 4'h0 |=> rdata == 8'h00)
    else $error("Flags survive power-on clear");
  a_rdata_idle: assert property (
    !bus.rd |=> rdata == 8'h00) else $error("Read data without read");
endmodule : rcu_assertions

bind rcu_top rcu_assertions u_chk (.core_clk, .rst, .reset_pin_n, .req, .low_voltage_default_disable,
  .supply_above_threshold, .stop_mode, .bus, .rdata, .clk_ctl, .system_reset, .sfr_init, .port_force_hiz,
  .dedicated_low_output_port_pin_out, .dedicated_low_output_port_pin_oe, .ram_write_block, .ram_retain_stop,
  .low_voltage_detector_reset, .watchdog_reset);

// >>> dv/rcu_ext_src.sv
/*
  Model of the external reset source and the supply monitor.
  Assumes the bench calls its tasks; pin has a pull-up, so idle is high.
*/
`timescale 1ns/100ps
module rcu_ext_src (
  input wire logic core_clk,
  output logic     reset_pin_n,
  output logic     supply_above_threshold
);
  initial begin
    reset_pin_n = 1'b1;
    supply_above_threshold = 1'b0;
  end
  // Low for exactly n sampled edges, so the minimum pulse can be hit or missed by one
  task automatic pin_low(input int n);
    @(posedge core_clk) reset_pin_n <= 1'b0;
    repeat (n) @(posedge core_clk);
    reset_pin_n <= 1'b1;
  endtask : pin_low
  task automatic supply(input logic v);
    @(posedge core_clk) supply_above_threshold <= v;
  endtask : supply
endmodule : rcu_ext_src

// >>> dv/rcu_top_tb.sv
/*
  Self-checking bench of the reset control unit: bus accesses, every reset cause.
  Assumes rcu_pkg, rcu_top, rcu_ext_src and the checker are compiled first.
*/
`timescale 1ns/100ps
module rcu_top_tb;
  import rcu_pkg::*;
  logic         core_clk, rst, reset_pin_n, supply_above_threshold, low_voltage_default_disable, stop_mode;
  logic         ded_pin_sw_out, ded_pin_sw_oe, irq, system_reset, sfr_init, port_force_hiz;
  logic         ram_write_block, ram_retain_stop, low_voltage_detector_reset, watchdog_reset;
  logic         dedicated_low_output_port_pin_out, dedicated_low_output_port_pin_oe;
  logic [7:0]   rdata;
  rcu_req_s     req;
  rcu_bus_s     bus;
  rcu_clk_ctl_s clk_ctl;
  int           n_mismatch = 0;
  int           check_count = 0;

  rcu_top uut (.core_clk, .rst, .reset_pin_n, .req, .low_voltage_default_disable, .supply_above_threshold,
    .stop_mode, .ded_pin_sw_out, .ded_pin_sw_oe, .bus, .rdata, .irq, .clk_ctl, .system_reset, .sfr_init,
    .port_force_hiz, .dedicated_low_output_port_pin_out, .dedicated_low_output_port_pin_oe, .ram_write_block,
    .ram_retain_stop, .low_voltage_detector_reset, .watchdog_reset);
  rcu_ext_src src (.core_clk, .reset_pin_n, .supply_above_threshold);

  task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk) bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge core_clk) bus.wr <= 1'b0;
    #1;
  endtask : wr
  task automatic rchk(input logic [3:0] a, input logic [7:0] e);
    @(posedge core_clk) bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge core_clk) bus.rd <= 1'b0;
    #1 chk("rdata", rdata, e);
  endtask : rchk
  task automatic cause(input rcu_req_s r);
    @(posedge core_clk) req <= r;
    @(posedge core_clk) req <= '0;
    #1;
  endtask : cause
  task automatic wait_run;
    int i;
    for (i = 0; i < 100 && system_reset !== 1'b0; i++) @(posedge core_clk);
    #1 chk("released", {7'h0, system_reset}, 8'h00);
  endtask : wait_run
  task automatic chk_pins(input logic [7:0] e);
    chk("pins", {4'h0, sfr_init, port_force_hiz, dedicated_low_output_port_pin_out,
      dedicated_low_output_port_pin_oe}, e);
  endtask : chk_pins
  task automatic print_verdict;
    $display("Checks %0d, mismatches %0d", check_count, n_mismatch);
    if (n_mismatch == 0 && check_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : print_verdict

  initial begin
    core_clk = 1'b0;
    forever #10 core_clk = ~core_clk;
  end
  // Whole sequence is just over a thousand cycles; this limit is 20000 cycles, over ten times that
  initial begin
    #400us;
    n_mismatch++;
    print_verdict();
  end
  initial begin
    rst = 1'b1;
    req = '0;
    bus = '0;
    stop_mode = 1'b0;
    low_voltage_default_disable = 1'b0;
    ded_pin_sw_out = 1'b1;
    ded_pin_sw_oe = 1'b0;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    repeat (20) @(posedge core_clk);
    #1 chk("hold", {7'h0, system_reset}, 8'h01);
    src.supply(1'b1);
    wait_run();
    chk("osc", {3'h0, clk_ctl}, 8'h1F);
    chk_pins(8'h02);
    rchk(4'h0, 8'h01);
    rchk(4'h0, 8'h00);
    rchk(4'h4, 8'h00);
    rchk(4'hF, 8'h00);
    wr(4'h4, 8'h07);
    cause(3'b001);
    chk("osc", {3'h0, clk_ctl}, 8'h00);
    chk("ext clk", {7'h0, clk_ctl.ext_main_clock_valid}, 8'h00);
    chk_pins(8'h0D);
    chk("wdt", {7'h0, watchdog_reset}, 8'h01);
    chk("lvd reset", {7'h0, low_voltage_detector_reset}, 8'h01);
    wait_run();
    rchk(4'h0, 8'h02);
    chk("irq", {7'h0, irq}, 8'h01);
    wr(4'h4, 8'h00);
    rchk(4'h2, 8'h02);
    chk("irq masked", {7'h0, irq}, 8'h00);
    wr(4'h4, 8'h07);
    wr(4'h3, 8'h02);
    rchk(4'h2, 8'h00);
    chk("irq cleared", {7'h0, irq}, 8'h00);
    stop_mode <= 1'b1;
    src.pin_low(499);
    repeat (3) @(posedge core_clk);
    #1 chk("short pin", {7'h0, system_reset}, 8'h00);
    src.pin_low(500);
    repeat (2) @(posedge core_clk);
    #1 chk("ram", {6'h0, ram_retain_stop, ram_write_block}, 8'h03);
    rchk(4'h5, 8'h03);
    stop_mode <= 1'b0;
    wait_run();
    rchk(4'h5, 8'h00);
    rchk(4'h0, 8'h04);
    wr(4'h1, 8'h01);
    cause(3'b010);
    chk("lvd reset", {7'h0, low_voltage_detector_reset}, 8'h00);
    // Lands while still held, so it must be refused and the readback keeps 1
    wr(4'h1, 8'h00);
    wait_run();
    rchk(4'h1, 8'h01);
    rchk(4'h0, 8'h01);
    cause(3'b001);
    wait_run();
    // Power-on clear held over a read: the unread watchdog flag must be gone
    @(posedge core_clk) req <= 3'b100;
    rchk(4'h0, 8'h00);
    @(posedge core_clk) req <= '0;
    wait_run();
    rchk(4'h0, 8'h00);
    rchk(4'h1, 8'h00);
    print_verdict();
  end
endmodule : rcu_top_tb
